/* File: verilog/eeprom_i2c_slave_front_end.sv */
// Functional notes
// [R1] Data line only pulled low or released
// [R2] Unconnected chip-select strap reads as zero
// [R3] Write-protect high blocks array writes
// [R4] Write-protect keeps select, address acks only
// [R5] Ignore bus until reset released
// [R6] Reset again stops all bus response
// [R7] Slave only; master supplies clock
// [R8] Start: data falls while clock high
// [R9] Master sends Start before every command
// [R10] Watch for Start except during write
// [R11] Stop: data rises while clock high
// [R12] Stop after write starts write cycle
// [R13] Read NoAck then Stop returns standby
// [R14] Release after eight bits; ninth acks
// [R15] Sample data on rising clock edge
// [R16] Master sends select byte MSB first
// [R17] Select byte: type, chip-select, direction
// [R18] Respond only on type and strap match
// [R19] Larger parts use select bits as address
// [R20] Direction one reads, zero writes
// [R21] Ack on match, else standby until Start
// [R22] Random read: dummy write, restart, read
// [R23] Sequential read continues while master acks
// [R24] During write cycle data output disabled
// [R25] Only Stop after data ack starts write
// [R26] Lines synchronised and edges detected
// [R27] Bit counter restarts on every Start; code restarts it only when no write cycle is running
//
// Purpose: Two-wire slave front end of a small serial memory
// Assumes: clk_sys at 20 MHz, bus clock much slower; unconnected pins
//          are pulled to zero by the pad ring
// Notes:   Memory array access goes through a simple write/read port
`timescale 1ns/1ps
`include "eeprom_front_defines.svh"
module eeprom_i2c_slave_front_end #(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
  parameter logic [1:0]  CAPACITY     = 2'h0
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      clkEn,
  input  wire logic                      sclIn,
  input  wire logic                      sdaIn,
  output logic                           sdaOut,
  output logic                           sdaOe_n,
  input  wire logic                      strap_sel_0,
  input  wire logic                      strap_sel_1,
  input  wire logic                      strap_sel_2,
  input  wire logic                      write_protect_in,
  output logic                           memWrite,
  output logic [`ADDR_WIDTH-1:0]         memAddr,
  output logic [7:0]                     memWdata,
  input  wire logic [7:0]                memRdata,
  output logic                           writeBusy,
  output logic                           standby
);
  eeprom_front_pkg::line_events_s lineEvents;
  eeprom_front_pkg::phase_e       phase;
  eeprom_front_pkg::select_s      selByte;
  logic [3:0]                     bitCount;
  logic [7:0]                     shiftIn;
  logic [7:0]                     shiftOut;
  logic                           ackDrive;
  logic                           dataDrive;
  logic                           writePending;
  logic                           afterDataAck;
  logic [`ADDR_WIDTH-1:0]         addrCount;
  logic [31:0]                    busyCount;
  logic [2:0]                     straps;
  logic [2:0]                     strapSync0;
  logic [2:0]                     strapSync1;
  logic [2:0]                     selMask;
  logic                           selMatch;
  logic                           wpSync0;
  logic                           wpSync1;
  logic                           protect;
  logic [7:0]                     rxByte;
  logic [`ADDR_WIDTH-1:0]         next_addr;

  line_sync u_line_sync (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .sclIn      (sclIn),
    .sdaIn      (sdaIn),
    .lineEvents (lineEvents)
  );

  // Address bits carried in the select byte per capacity
  function automatic logic [2:0] upper_mask(input logic [1:0] cap);
    unique case (cap)
      2'h0:    upper_mask = 3'h0;
      2'h1:    upper_mask = 3'h1;
      2'h2:    upper_mask = 3'h3;
      default: upper_mask = 3'h7;
    endcase
  endfunction

  // Write-protect is a pin: synchronise before use
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wpSync0 <= 1'b0;
      wpSync1 <= 1'b0;
    end else if (clkEn) begin
      wpSync0 <= write_protect_in;
      wpSync1 <= wpSync0;
    end
  end
  assign protect = wpSync1; // [R3]

  // Straps are pins too; a floating one is pulled low at the pad
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strapSync0 <= 3'h0;
      strapSync1 <= 3'h0;
    end else if (clkEn) begin
      strapSync0 <= {strap_sel_2, strap_sel_1, strap_sel_0};
      strapSync1 <= strapSync0;
    end
  end

  assign straps   = strapSync1; // [R2]
  assign selMask  = upper_mask(CAPACITY);
  assign rxByte   = {shiftIn[6:0], lineEvents.sdaLevel};
  assign selMatch = (rxByte[`TYPE_ID_MSB:`TYPE_ID_LSB] == `DEV_TYPE_ID) &&
                    (((rxByte[`CHIP_SEL_MSB:`CHIP_SEL_LSB] ^ straps) & ~selMask) == 3'h0);
                    // [R17] [R18] [R19]
  assign next_addr = addrCount + `ADDR_WIDTH'(1);

  // Bit counter and shift register, reset by every Start outside a write cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin // [R5] [R6]
      bitCount <= 4'h0;
      shiftIn  <= 8'h00;
    end else if (clkEn) begin
      if (lineEvents.startSeen && !writeBusy) begin
        bitCount <= 4'h0; // [R27]
        shiftIn  <= 8'h00;
      end else if (lineEvents.sclRise && phase != eeprom_front_pkg::PH_IDLE) begin
        shiftIn <= rxByte; // [R15] [R16]
        if (bitCount == `BIT_ACK) begin
          bitCount <= 4'h0;
        end else begin
          bitCount <= bitCount + 4'h1;
        end
      end
    end
  end

  // Byte phase machine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase        <= eeprom_front_pkg::PH_IDLE;
      selByte      <= '0;
      ackDrive     <= 1'b0;
      afterDataAck <= 1'b0;
      writePending <= 1'b0;
    end else if (clkEn) begin
      if (lineEvents.startSeen && !writeBusy) begin // [R10]
        phase        <= eeprom_front_pkg::PH_SELECT;
        afterDataAck <= 1'b0;
        writePending <= 1'b0;
        ackDrive     <= 1'b0;
      end else if (lineEvents.stopSeen) begin // [R11] [R13]
        phase        <= eeprom_front_pkg::PH_IDLE;
        ackDrive     <= 1'b0;
        afterDataAck <= 1'b0;
        writePending <= 1'b0;
      end else if (lineEvents.sclRise) begin
        // A Stop after a data ack follows one more clock rise
        if (bitCount != `BIT_ACK && bitCount != 4'h0) begin
          afterDataAck <= 1'b0;
        end
        if (bitCount == `BIT_LAST) begin
          unique case (phase)
            eeprom_front_pkg::PH_SELECT: begin
              selByte <= rxByte;
              if (!selMatch) begin
                phase <= eeprom_front_pkg::PH_IDLE; // [R21]
              end
            end
            eeprom_front_pkg::PH_WDATA: begin
              writePending <= writePending | ~protect; // [R3]
            end
            default: begin
            end
          endcase
        end else if (bitCount == `BIT_ACK) begin
          unique case (phase)
            eeprom_front_pkg::PH_SELECT: begin
              phase <= selByte.readDir ? eeprom_front_pkg::PH_RDATA // [R20]
                                       : eeprom_front_pkg::PH_ADDRESS;
            end
            eeprom_front_pkg::PH_ADDRESS: begin
              phase <= eeprom_front_pkg::PH_WDATA;
            end
            eeprom_front_pkg::PH_WDATA: begin
              afterDataAck <= 1'b1; // [R25]
            end
            eeprom_front_pkg::PH_RDATA: begin
              if (lineEvents.sdaLevel) begin
                phase <= eeprom_front_pkg::PH_IDLE; // [R23] [R13]
              end
            end
            default: begin
            end
          endcase
        end
      end else if (lineEvents.sclFall) begin
        // Ack slot opens after the eighth bit of a received byte
        ackDrive <= 1'b0;
        if (bitCount == `BIT_ACK && selByte.typeId == `DEV_TYPE_ID) begin
          unique case (phase)
            eeprom_front_pkg::PH_SELECT,
            eeprom_front_pkg::PH_RDATA: begin
              ackDrive <= phase == eeprom_front_pkg::PH_SELECT; // [R21] [R14]
            end
            eeprom_front_pkg::PH_ADDRESS: begin
              ackDrive <= 1'b1; // [R4]
            end
            eeprom_front_pkg::PH_WDATA: begin
              ackDrive <= ~protect; // [R4]
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Address counter, write data, and the array write port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addrCount <= '0;
      memWdata  <= 8'h00;
      memWrite  <= 1'b0;
    end else if (clkEn) begin
      memWrite <= 1'b0;
      if (lineEvents.sclRise && bitCount == `BIT_LAST) begin
        unique case (phase)
          eeprom_front_pkg::PH_SELECT: begin
            addrCount[10:8] <= (rxByte[3:1] & selMask) | (addrCount[10:8] & ~selMask); // [R19]
          end
          eeprom_front_pkg::PH_ADDRESS: begin
            addrCount[7:0] <= rxByte;
          end
          eeprom_front_pkg::PH_WDATA: begin
            if (!protect) begin // [R3]
              memWdata <= rxByte;
              memWrite <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      if (lineEvents.sclRise && bitCount == `BIT_ACK) begin
        if (phase == eeprom_front_pkg::PH_WDATA && !protect) begin
          addrCount[3:0] <= addrCount[3:0] + 4'h1;
        end else if (phase == eeprom_front_pkg::PH_RDATA) begin
          addrCount <= next_addr; // [R23]
        end
      end
    end
  end
  assign memAddr = addrCount;

  // Internal write cycle timer, blind to the bus while it runs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      writeBusy <= 1'b0;
      busyCount <= 32'h0;
    end else if (clkEn) begin
      if (writeBusy) begin
        if (busyCount == 32'h1) begin
          writeBusy <= 1'b0;
        end
        busyCount <= busyCount - 32'h1;
      end else if (lineEvents.stopSeen && afterDataAck && writePending) begin
        writeBusy <= 1'b1; // [R12] [R25]
        busyCount <= WRITE_CYCLES;
      end
    end
  end

  // Read data loads at the ack slot and shifts out on falling edges
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shiftOut  <= 8'hFF;
      dataDrive <= 1'b0;
    end else if (clkEn) begin
      if (lineEvents.startSeen || lineEvents.stopSeen || writeBusy) begin
        dataDrive <= 1'b0;
      end else if (lineEvents.sclFall && phase == eeprom_front_pkg::PH_RDATA) begin
        if (bitCount == 4'h0) begin
          shiftOut  <= {memRdata[6:0], 1'b1};
          dataDrive <= ~memRdata[7]; // [R16]
        end else if (bitCount < `BIT_ACK) begin
          shiftOut  <= {shiftOut[6:0], 1'b1};
          dataDrive <= ~shiftOut[7];
        end else begin
          dataDrive <= 1'b0; // [R14]
        end
      end else if (lineEvents.sclFall) begin
        dataDrive <= 1'b0;
      end
    end
  end

  // Open-drain: drive only a zero, and never during a write cycle
  assign sdaOut  = 1'b0; // [R1]
  assign sdaOe_n = ~((ackDrive | dataDrive) & ~writeBusy); // [R24] [R7]
  assign standby = (phase == eeprom_front_pkg::PH_IDLE) & ~writeBusy;

  AST_BUSY_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R24]
    writeBusy |-> sdaOe_n) else $error("data line driven during write cycle");
  AST_RESET_IDLE: assert property (@(posedge clk_sys) // [R5]
    !rst_n |=> (phase == eeprom_front_pkg::PH_IDLE && !writeBusy && sdaOe_n))
    else $error("reset did not return to standby");
  AST_START_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R27]
    (clkEn && lineEvents.startSeen && !writeBusy) |=> bitCount == 4'h0)
    else $error("bit counter not cleared by Start");
  AST_START_PHASE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
    (clkEn && lineEvents.startSeen && !writeBusy) |=> phase == eeprom_front_pkg::PH_SELECT)
    else $error("Start did not open select phase");
  AST_STOP_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
    (clkEn && lineEvents.stopSeen) |=> phase == eeprom_front_pkg::PH_IDLE)
    else $error("Stop did not end communication");
  AST_WP_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
    memWrite |-> !$past(protect)) else $error("array written while protected");
  AST_WP_NOACK: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
    (clkEn && lineEvents.sclFall && bitCount == `BIT_ACK && protect
     && phase == eeprom_front_pkg::PH_WDATA) |=> !ackDrive)
    else $error("data byte acked while protected");
  AST_WRITE_START: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R25]
    $rose(writeBusy) |-> $past(afterDataAck) && $past(lineEvents.stopSeen))
    else $error("write cycle started outside data ack slot");
  AST_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
    !sdaOe_n |-> sdaOut == 1'b0) else $error("data line driven high");
  COV_SELECT_ACK: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ackDrive && phase == eeprom_front_pkg::PH_SELECT);
  COV_WRITE_CYCLE: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(writeBusy));
  COV_READ_BYTE: cover property (@(posedge clk_sys) disable iff (!rst_n) dataDrive);
  AST_MISMATCH_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R21]
    (clkEn && lineEvents.sclRise && bitCount == `BIT_LAST && !selMatch
     && phase == eeprom_front_pkg::PH_SELECT) |=> phase == eeprom_front_pkg::PH_IDLE)
    else $error("mismatched select byte not released");
  COV_PROTECT_STOP: cover property (@(posedge clk_sys) disable iff (!rst_n)
    protect && lineEvents.stopSeen && phase == eeprom_front_pkg::PH_WDATA);
endmodule

/* File: verilog/eeprom_front_defines.svh */
// Purpose: Constants for the serial memory slave front end
// Assumes: Included by bare name
// Notes:   Offsets, field positions and timing counts
`ifndef EEPROM_FRONT_DEFINES_SVH
`define EEPROM_FRONT_DEFINES_SVH
`define TYPE_ID_MSB      7
`define TYPE_ID_LSB      4
`define CHIP_SEL_MSB     3
`define CHIP_SEL_LSB     1
`define DIR_BIT          0
`define DEV_TYPE_ID      4'hA
`define ADDR_WIDTH       11
`define BIT_LAST         4'h7
`define BIT_ACK          4'h8
`define WRITE_TIME_NS    5000000
`define CLK_PERIOD_NS    50
`define WRITE_CYCLES     (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`endif

/* File: verilog/eeprom_front_pkg.sv */
// Purpose: Types for the serial memory slave front end
// Assumes: Constants come from eeprom_front_defines.svh
// Notes:   Byte phase states and the command record
package eeprom_front_pkg;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SELECT,
    PH_ADDRESS,
    PH_WDATA,
    PH_RDATA
  } phase_e;
  typedef struct packed {
    logic [3:0] typeId;
    logic [2:0] chipSel;
    logic       readDir;
  } select_s;
  typedef struct packed {
    logic       sclRise;
    logic       sclFall;
    logic       startSeen;
    logic       stopSeen;
    logic       sdaLevel;
  } line_events_s;
endpackage

/* File: verilog/line_sync.sv */
// Purpose: Two-stage synchroniser and edge detector for the bus lines
// Assumes: Lines come from outside the clk_sys domain
// Notes:   Start and Stop are seen from registered copies only
`timescale 1ns/1ps
`include "eeprom_front_defines.svh"
module line_sync (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         clkEn,
  input  wire logic                         sclIn,
  input  wire logic                         sdaIn,
  output eeprom_front_pkg::line_events_s    lineEvents
);
  logic [1:0] sclMeta;
  logic [1:0] sdaMeta;
  logic       sclLast;
  logic       sdaLast;

  // First stage is read by the second stage only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclMeta <= 2'h3;
      sdaMeta <= 2'h3;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else if (clkEn) begin
      sclMeta <= {sclMeta[0], sclIn}; // [R26]
      sdaMeta <= {sdaMeta[0], sdaIn}; // [R26]
      sclLast <= sclMeta[1];
      sdaLast <= sdaMeta[1];
    end
  end

  always_comb begin
    lineEvents.sclRise   = sclMeta[1] & ~sclLast;                       // [R15]
    lineEvents.sclFall   = ~sclMeta[1] & sclLast;
    lineEvents.startSeen = sclMeta[1] & sclLast & sdaLast & ~sdaMeta[1]; // [R8]
    lineEvents.stopSeen  = sclMeta[1] & sclLast & ~sdaLast & sdaMeta[1]; // [R11]
    lineEvents.sdaLevel  = sdaMeta[1];
  end
endmodule

/* File: tb/i2c_master_model.sv */
// Purpose: Two-wire bus master model for the memory front end bench
// Assumes: Data line has a pull-up; sdaLow high pulls it low
// Notes:   One bus clock period is eight clk_sys cycles (400 ns)
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Start is cond(0,1), Stop is cond(1,0); data moves while clock is high
  task automatic cond(input logic first, input logic last);
    scl <= 1'b0;
    tick(2);
    sdaLow <= first;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sdaLow <= last;
    tick(2);
  endtask
  task automatic bitSlot(input logic low, output logic lvl);
    scl <= 1'b0;
    tick(2);
    sdaLow <= low;
    tick(2);
    scl <= 1'b1;
    tick(3);
    lvl = sdaLine;
    tick(1);
  endtask
  task automatic byteTx(input logic [7:0] d, output logic ack);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      bitSlot(!d[i], lvl);
    end
    bitSlot(1'b0, lvl);
    ack = (lvl === 1'b0);
  endtask
  task automatic byteRx(input logic ackIt, output logic [7:0] d);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      bitSlot(1'b0, lvl);
      d[i] = lvl;
    end
    bitSlot(ackIt, lvl);
  endtask
endmodule

/* File: tb/eeprom_i2c_slave_front_end_tb.sv */
// Purpose: Self-checking bench for the memory slave front end
// Assumes: Straps 101, capacity 0, shortened write cycle
// Notes:   Master model drives the bus clock and data
`timescale 1ns/1ps
`include "eeprom_front_defines.svh"
module eeprom_i2c_slave_front_end_tb;
  localparam int         WCYC = 200;
  localparam logic [7:0] SELW = {`DEV_TYPE_ID, 3'h5, 1'b0};
  localparam logic [7:0] SELR = {`DEV_TYPE_ID, 3'h5, 1'b1};
  logic                    clk_sys = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    wp = 1'b0;
  logic                    clkEn = 1'b1;
  logic [2:0]              strapSel = 3'h5;
  logic                    scl;
  logic                    sdaLow;
  logic                    sdaLine;
  logic                    sdaOut;
  logic                    sdaOe_n;
  logic                    memWrite;
  logic [`ADDR_WIDTH-1:0]  memAddr;
  logic [7:0]              memWdata;
  logic [7:0]              memRdata;
  logic                    writeBusy;
  logic                    standby;
  logic [7:0]              mem [0:2047];
  logic                    ack;
  logic [7:0]              rd;
  int                      badCount = 0;
  int                      checksDone = 0;
  int                      cycles = 0;
  int                      t0;
  always #25 clk_sys = ~clk_sys;
  // Wired-AND data line with pull-up
  assign sdaLine = !(sdaLow || sdaOe_n === 1'b0);
  assign memRdata = mem[memAddr];
  eeprom_i2c_slave_front_end #(
    .WRITE_CYCLES (WCYC),
    .CAPACITY     (2'h0)
  ) i_dut (
    .clk_sys (clk_sys), .rst_n (rst_n), .clkEn (clkEn), .sclIn (scl),
    .sdaIn (sdaLine), .sdaOut (sdaOut), .sdaOe_n (sdaOe_n),
    .strap_sel_0 (strapSel[0]), .strap_sel_1 (strapSel[1]), .strap_sel_2 (strapSel[2]),
    .write_protect_in (wp), .memWrite (memWrite), .memAddr (memAddr),
    .memWdata (memWdata), .memRdata (memRdata), .writeBusy (writeBusy),
    .standby (standby)
  );
  i2c_master_model master (
    .clk_sys (clk_sys), .sdaLine (sdaLine), .scl (scl), .sdaLow (sdaLow)
  );
  always @(posedge clk_sys) begin
    cycles++;
    if (memWrite === 1'b1) begin
      mem[memAddr] <= memWdata;
    end
    if (cycles == 20000) begin
      badCount++;
      testDone();
    end
  end
  task automatic testDone();
    if (badCount == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sendAck(input logic [7:0] d, input logic expAck);
    master.byteTx(d, ack);
    check(8'(ack), 8'(expAck));
  endtask
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'hFF;
    end
    mem[11'h014] = 8'h00;
    repeat (12) @(posedge clk_sys);
    check(8'(sdaOe_n), 8'h01);
    rst_n <= 1'b1;
    master.tick(4);
    check(8'(standby), 8'h01);
    master.cond(1'b0, 1'b1);
    sendAck(SELW, 1'b1);
    sendAck(8'h12, 1'b1);
    sendAck(8'h5A, 1'b1);
    sendAck(8'hA5, 1'b1);
    check(8'(sdaOut), 8'h00);
    master.cond(1'b1, 1'b0);
    t0 = cycles;
    master.tick(4);
    check(8'(writeBusy), 8'h01);
    check(mem[11'h012], 8'h5A);
    check(mem[11'h013], 8'hA5);
    // Clock enable low freezes the write cycle timer for 20 cycles
    clkEn <= 1'b0;
    master.tick(20);
    check(8'(writeBusy), 8'h01);
    clkEn <= 1'b1;
    // Polling during the write cycle gets no answer
    master.cond(1'b0, 1'b1);
    sendAck(SELW, 1'b0);
    while (writeBusy !== 1'b0 && cycles - t0 < 1000) begin
      @(posedge clk_sys);
    end
    check(8'((cycles - t0) inside {[WCYC + 18:WCYC + 26]}), 8'h01);
    master.cond(1'b1, 1'b0);
    // Stop right after the address slot
    master.cond(1'b0, 1'b1);
    sendAck(SELW, 1'b1);
    sendAck(8'h40, 1'b1);
    master.cond(1'b1, 1'b0);
    master.tick(6);
    check(8'(writeBusy), 8'h00);
    master.cond(1'b0, 1'b1);
    sendAck(SELW ^ 8'h02, 1'b0);
    check(8'(standby), 8'h01);
    master.cond(1'b0, 1'b1);
    sendAck(SELW ^ 8'h80, 1'b0);
    strapSel <= 3'h0;
    master.cond(1'b0, 1'b1);
    sendAck(8'hA0, 1'b1);
    master.cond(1'b1, 1'b0);
    strapSel <= 3'h5;
    wp <= 1'b1;
    master.cond(1'b0, 1'b1);
    sendAck(SELW, 1'b1);
    sendAck(8'h30, 1'b1);
    sendAck(8'h11, 1'b0);
    master.cond(1'b1, 1'b0);
    master.tick(6);
    check(8'(writeBusy), 8'h00);
    check(mem[11'h030], 8'hFF);
    wp <= 1'b0;
    // Random read with a partial byte dropped by the restart
    master.cond(1'b0, 1'b1);
    sendAck(SELW, 1'b1);
    sendAck(8'h12, 1'b1);
    for (int i = 0; i < 3; i++) begin
      master.bitSlot(1'b0, ack);
    end
    master.cond(1'b0, 1'b1);
    sendAck(SELR, 1'b1);
    master.byteRx(1'b1, rd);
    check(rd, 8'h5A);
    master.byteRx(1'b0, rd);
    check(rd, 8'hA5);
    master.cond(1'b1, 1'b0);
    master.tick(4);
    check(8'(standby), 8'h01);
    check(8'(sdaOe_n), 8'h01);
    // Reset in mid-read silences the device
    master.cond(1'b0, 1'b1);
    sendAck(SELR, 1'b1);
    rst_n <= 1'b0;
    master.tick(2);
    check(8'(sdaOe_n), 8'h01);
    master.byteRx(1'b0, rd);
    check(rd, 8'hFF);
    rst_n <= 1'b1;
    master.tick(3);
    master.cond(1'b1, 1'b0);
    check(8'(standby), 8'h01);
    testDone();
  end
endmodule
